// *** logic/blank_filter.sv ***
// blanking filter: one-cycle pulse once the input has stood high for LEN cycles
// assumes the input is synchronous to clk_sys_i
`timescale 1ns/1ps
module blank_filter #(
   parameter int unsigned LEN = 190,
   parameter int unsigned W = 16
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic level_i,
   output logic expire_o
);
   if (LEN < 2 || LEN >= (1 << W)) begin : g_chk
      $error("blank_filter: LEN out of range");
   end

   logic [W-1:0] cnt_ff;
   wire at_end = (cnt_ff == W'(LEN));
   wire hit = level_i && (cnt_ff == W'(LEN - 1));

   // a drop restarts the count, so short spikes never shut anything off
   always_ff @(posedge clk_sys_i) begin
      if (rst_i || !level_i) begin
         cnt_ff <= '0;
         expire_o <= 1'b0;
      end else begin
         cnt_ff <= at_end ? cnt_ff : cnt_ff + W'(1);
         expire_o <= hit;
      end
   end
endmodule

// *** logic/hold_if.sv ***
// start and busy pair between the sequencer and a hold timer
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface hold_if;
   logic start;
   logic active;
   modport ctrl (output start, input active);
   modport timer (input start, output active);
endinterface

// *** logic/hold_timer.sv ***
// hold timer: active for HOLD cycles after a start pulse
// assumes start is a one-cycle pulse; a start while active restarts the hold
`timescale 1ns/1ps
module hold_timer #(
   parameter logic [31:0] HOLD = 32'd1500000
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   hold_if.timer h
);
   if (HOLD == 32'd0) begin : g_chk
      $error("hold_timer: HOLD must be nonzero");
   end

   logic [31:0] cnt_ff;

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         cnt_ff <= '0;
         h.active <= 1'b0;
      end else if (h.start) begin
         cnt_ff <= HOLD - 32'd1;
         h.active <= 1'b1;
      end else begin
         cnt_ff <= (cnt_ff != 32'd0) ? cnt_ff - 32'd1 : cnt_ff;
         h.active <= (cnt_ff != 32'd0);
      end
   end
endmodule

// *** logic/motor_guard.sv ***
// motor driver protection sequencer: gate drive, fault output, register port
// assumes synchronous comparator, sensor and strobe inputs on clk_sys_i
//
// Behaviour
// [RULE1] low overcurrent held past blanking cuts gates
// [RULE2] current limit cut clears each carrier start
// [RULE3] high overcurrent held past blanking trips
// [RULE4] trip holds gates off, then resumes
// [RULE5] fault output high during trip hold
// [RULE6] controller stops motor, waits before restart
// [RULE7] overtemperature cuts gates with hysteresis
// [RULE8] fault high during thermal cutoff, then resume
// [RULE9] no sensor change for stall time: stall
// [RULE10] stall hold keeps gates off, fault high
// [RULE11] fault follows rotation against selected direction
// [RULE12] reverse rotation switches to trapezoidal within sector
// [RULE13] drive scheme from direction pin and rotation
// [RULE14] all-equal sensors: sensor fault, gates off
// [RULE15] valid sensors drive per commutation table
// [RULE16] forward table order of sensor states
// [RULE17] reverse table order of sensor states
// [RULE18] no protection active: fault output low
// [RULE19] controller withdraws drive before trip hold ends
// [RULE20] intervals counted in ticks; drops restart blanking
// [RULE21] fault output is OR of all sources
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`include "motor_guard_map.svh"
module motor_guard
   import motor_guard_pkg::*;
#(
   parameter logic [31:0] TRIP_HOLD_CYC = 32'(`TRIP_HOLD_CYC),
   parameter logic [31:0] STALL_DETECT_CYC = 32'(`STALL_DETECT_CYC),
   parameter logic [31:0] STALL_HOLD_CYC = 32'(`STALL_HOLD_CYC)
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic limit_threshold_i,
   input wire logic trip_threshold_i,
   input wire logic overtemp_set_level_i,
   input wire logic overtemp_clear_level_i,
   input wire logic rotor_sense_u_i,
   input wire logic rotor_sense_v_i,
   input wire logic rotor_sense_w_i,
   input wire logic direction_select_i,
   input wire logic [2:0] sine_hi_i,
   input wire logic [2:0] sine_lo_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   output logic [2:0] gate_hi_o,
   output logic [2:0] gate_lo_o,
   output logic fault_out_o,
   output logic trap_mode_o
);
   if (STALL_DETECT_CYC < 32'd2) begin : g_chk
      $error("motor_guard: stall detect count too small");
   end

   // forward sector of a sensor state (u,v,w); 7 marks all-equal states
   function automatic sector_t sector_of(input phase_t s);
      case (s)
         3'b101: sector_of = 3'd0;
         3'b100: sector_of = 3'd1;
         3'b110: sector_of = 3'd2;
         3'b010: sector_of = 3'd3;
         3'b011: sector_of = 3'd4;
         3'b001: sector_of = 3'd5;
         default: sector_of = 3'd7;
      endcase
   endfunction

   // gates for a sector: {hi u,v,w, lo u,v,w}
   function automatic logic [5:0] gates_of(input sector_t k);
      case (k)
         3'd0: gates_of = 6'b010_100;
         3'd1: gates_of = 6'b001_100;
         3'd2: gates_of = 6'b001_010;
         3'd3: gates_of = 6'b100_010;
         3'd4: gates_of = 6'b100_001;
         3'd5: gates_of = 6'b010_001;
         default: gates_of = 6'b000_000;
      endcase
   endfunction

   function automatic sector_t step(input sector_t k, input logic up);
      if (up) begin
         step = (k == 3'd5) ? 3'd0 : k + 3'd1;
      end else begin
         step = (k == 3'd0) ? 3'd5 : k - 3'd1;
      end
   endfunction

   // registers
   logic enable_ff;
   logic [`CARRIER_W-1:0] carrier_len_ff;
   logic [`CARRIER_W-1:0] carrier_cnt_ff;
   logic limit_cut_ff;
   logic thermal_cutoff_ff;
   phase_t sense_prev_ff;
   logic [31:0] stall_cnt_ff;
   logic rot_fwd_ff;
   logic rot_seen_ff;
   drive_state_t drive_ff;
   localparam logic [31:0] CTRL_RST = `CTRL_RESET;

   hold_if trip_h ();
   hold_if stall_h ();

   phase_t sense;
   assign sense = {rotor_sense_u_i, rotor_sense_v_i, rotor_sense_w_i};

   wire limit_expire;
   wire trip_expire;

   blank_filter #(.LEN(`LIMIT_BLANK_CYC), .W(16)) u_limit_blank ( // RULE1 RULE20
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .level_i(limit_threshold_i),
      .expire_o(limit_expire)
   );
   blank_filter #(.LEN(`TRIP_BLANK_CYC), .W(16)) u_trip_blank ( // RULE3 RULE20
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .level_i(trip_threshold_i),
      .expire_o(trip_expire)
   );
   hold_timer #(.HOLD(TRIP_HOLD_CYC)) u_trip_hold (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .h(trip_h.timer)
   );
   hold_timer #(.HOLD(STALL_HOLD_CYC)) u_stall_hold (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .h(stall_h.timer)
   );

   // carrier period start; a zero period is taken as one cycle
   wire carrier_start = (carrier_cnt_ff == '0);
   wire [`CARRIER_W-1:0] nxt_carrier_cnt =
      (carrier_cnt_ff >= carrier_len_ff) ? '0 : carrier_cnt_ff + `CARRIER_W'(1);

   // set wins over the carrier clear so a cut at the boundary is not lost
   wire nxt_limit_cut = limit_expire || (limit_cut_ff && !carrier_start); // RULE1 RULE2

   assign trip_h.start = trip_expire; // RULE3

   // hysteresis: set above the upper level, cleared only at the lower one
   wire nxt_thermal = overtemp_set_level_i ||
      (thermal_cutoff_ff && !overtemp_clear_level_i); // RULE7

   // rotation tracking
   wire sector_t cur_sec = sector_of(sense);
   wire sector_t prev_sec = sector_of(sense_prev_ff);
   wire sensor_fault = (cur_sec == 3'd7); // RULE14
   wire sense_moved = (sense != sense_prev_ff);
   wire both_valid = !sensor_fault && (prev_sec != 3'd7);
   wire step_fwd = both_valid && (cur_sec == step(prev_sec, 1'b1));
   wire step_rev = both_valid && (cur_sec == step(prev_sec, 1'b0));

   // stall counter: restarts on any sensor change and during the stall hold
   wire stall_fire = (stall_cnt_ff == STALL_DETECT_CYC - 32'd1) && !sense_moved; // RULE9
   assign stall_h.start = stall_fire && !stall_h.active;
   wire [31:0] nxt_stall_cnt = (sense_moved || stall_h.active || stall_fire) ? 32'd0 :
      stall_cnt_ff + 32'd1;

   // direction decided at each sector step; cleared by a stall
   wire nxt_rot_seen = (rot_seen_ff || step_fwd || step_rev) && !stall_fire;
   wire nxt_rot_fwd = step_fwd ? 1'b1 : (step_rev ? 1'b0 : rot_fwd_ff);
   wire reverse_rot = nxt_rot_seen && (nxt_rot_fwd != direction_select_i); // RULE11

   // trapezoidal while rotating against the pin or before rotation is known
   wire nxt_trap = !nxt_rot_seen || reverse_rot; // RULE12 RULE13

   // the stall start cuts the gates in the same cycle that raises the fault
   wire gates_cut = limit_cut_ff || nxt_limit_cut || trip_h.active || trip_expire ||
      nxt_thermal || stall_h.start || stall_h.active || sensor_fault ||
      !enable_ff; // RULE4 RULE10 RULE14

   // reverse table is the forward one shifted half a turn
   wire sector_t trap_sec = direction_select_i ? cur_sec :
      ((cur_sec >= 3'd3) ? cur_sec - 3'd3 : cur_sec + 3'd3); // RULE16 RULE17
   wire [5:0] trap_gates = gates_of(sensor_fault ? 3'd7 : trap_sec); // RULE15

   wire drive_state_t nxt_drive = gates_cut ? DRV_OFF : (nxt_trap ? DRV_TRAP : DRV_SINE);
   logic [5:0] nxt_gates;
   always_comb begin
      case (nxt_drive)
         DRV_TRAP: nxt_gates = trap_gates;
         DRV_SINE: nxt_gates = {sine_hi_i, sine_lo_i};
         DRV_OFF: nxt_gates = 6'b000_000;
         default: nxt_gates = 6'b000_000;
      endcase
   end

   wire nxt_fault = trip_h.active || trip_expire || nxt_thermal || stall_h.active ||
      stall_h.start || reverse_rot || sensor_fault; // RULE5 RULE8 RULE18 RULE21

   // register port
   wire wr_ctrl = wr_i && (addr_i == `REG_CTRL);
   wire wr_carrier = wr_i && (addr_i == `REG_CARRIER);
   logic [31:0] status_word;
   always_comb begin
      status_word = '0;
      status_word[`ST_LIMIT_BIT] = limit_cut_ff;
      status_word[`ST_TRIP_BIT] = trip_h.active;
      status_word[`ST_THERMAL_BIT] = thermal_cutoff_ff;
      status_word[`ST_STALL_BIT] = stall_h.active;
      status_word[`ST_REVERSE_BIT] = rot_seen_ff && (rot_fwd_ff != direction_select_i);
      status_word[`ST_SENSOR_BIT] = sensor_fault;
      status_word[`ST_TRAP_BIT] = trap_mode_o;
      status_word[`ST_FAULT_BIT] = fault_out_o;
      status_word[`ST_ROT_FWD_BIT] = rot_fwd_ff;
      status_word[`ST_ROT_SEEN_BIT] = rot_seen_ff;
   end
   logic [31:0] nxt_rdata;
   always_comb begin
      case (addr_i)
         `REG_CTRL: nxt_rdata = {31'd0, enable_ff};
         `REG_CARRIER: nxt_rdata = {16'd0, carrier_len_ff};
         `REG_STATUS: nxt_rdata = status_word;
         `REG_SENSE: nxt_rdata = {24'd0, 2'd0, prev_sec, sense_prev_ff};
         default: nxt_rdata = 32'd0;
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         enable_ff <= CTRL_RST[`CTRL_ENABLE_BIT];
         carrier_len_ff <= `CARRIER_RESET;
         rdata_o <= '0;
      end else begin
         if (wr_ctrl) begin
            enable_ff <= wdata_i[`CTRL_ENABLE_BIT];
         end
         if (wr_carrier) begin
            carrier_len_ff <= wdata_i[`CARRIER_W-1:0];
         end
         rdata_o <= rd_i ? nxt_rdata : 32'd0;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         carrier_cnt_ff <= '0;
         limit_cut_ff <= 1'b0;
         thermal_cutoff_ff <= 1'b0;
         sense_prev_ff <= '0;
         stall_cnt_ff <= '0;
         rot_fwd_ff <= 1'b0;
         rot_seen_ff <= 1'b0;
      end else begin
         carrier_cnt_ff <= nxt_carrier_cnt;
         limit_cut_ff <= nxt_limit_cut;
         thermal_cutoff_ff <= nxt_thermal;
         sense_prev_ff <= sense;
         stall_cnt_ff <= nxt_stall_cnt;
         rot_fwd_ff <= nxt_rot_fwd;
         rot_seen_ff <= nxt_rot_seen;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         drive_ff <= DRV_OFF;
         gate_hi_o <= '0;
         gate_lo_o <= '0;
         fault_out_o <= 1'b0;
         trap_mode_o <= 1'b1;
      end else begin
         drive_ff <= nxt_drive;
         gate_hi_o <= nxt_gates[5:3];
         gate_lo_o <= nxt_gates[2:0];
         fault_out_o <= nxt_fault;
         trap_mode_o <= nxt_trap;
      end
   end

   // checks
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   wire gates_any = |{gate_hi_o, gate_lo_o};

   limit_cut_off_a: assert property (limit_expire |=> !gates_any) // RULE1
      else $error("gates on after current limit blanking expired");
   limit_release_a: assert property ($fell(limit_cut_ff) |-> $past(carrier_start)) // RULE2
      else $error("current limit cut cleared outside carrier start");
   trip_blank_a: assert property ( // RULE3
      ($rose(trip_threshold_i) && !trip_h.active) ##0 trip_threshold_i [*8] |-> !trip_h.active)
      else $error("trip entered before blanking elapsed");
   trip_hold_off_a: assert property (trip_h.active |=> !gates_any) // RULE4
      else $error("gates on during trip hold");
   trip_fault_a: assert property (trip_h.active |=> fault_out_o) // RULE5
      else $error("fault output low during trip hold");
   thermal_hyst_a: assert property ( // RULE7 RULE8
      thermal_cutoff_ff && !overtemp_set_level_i && !overtemp_clear_level_i
      |=> thermal_cutoff_ff ##0 fault_out_o && !gates_any)
      else $error("thermal cutoff released above the clear level");
   stall_enter_a: assert property (stall_fire |=> stall_h.active [*2]) // RULE9 RULE10
      else $error("stall hold not entered after stall detect");
   reverse_fault_a: assert property ( // RULE11 RULE12
      reverse_rot && !gates_cut |=> fault_out_o && trap_mode_o)
      else $error("reverse rotation not flagged or not trapezoidal");
   sensor_off_a: assert property (sensor_fault |=> !gates_any && fault_out_o) // RULE14
      else $error("sensor fault did not cut gates");
   trap_table_a: assert property ( // RULE16
      drive_ff == DRV_TRAP |-> $past(sense) == 3'b101 &&
      $past(direction_select_i) |-> gate_hi_o == 3'b010 && gate_lo_o == 3'b100)
      else $error("forward table wrong for sensor state 101");
   quiet_fault_a: assert property ( // RULE18 RULE21
      !trip_h.active && !trip_expire && !overtemp_set_level_i && !thermal_cutoff_ff &&
      !stall_h.active && !stall_fire && !sensor_fault && !sense_moved &&
      !(rot_seen_ff && (rot_fwd_ff != direction_select_i)) |=> !fault_out_o)
      else $error("fault output high with no source active");
   limit_drop_a: assert property (!limit_threshold_i |=> !limit_expire [*2]) // RULE20
      else $error("blanking not restarted by a drop");

   // gate, timer and carrier checks
   trip_enter_a: assert property (trip_expire |=> trip_h.active && fault_out_o) // RULE3 RULE5
      else $error("trip hold not entered after trip blanking");
   limit_hold_a: assert property (limit_cut_ff && !carrier_start |=> limit_cut_ff) // RULE2
      else $error("current limit cut released inside a carrier period");
   carrier_wrap_a: assert property (carrier_cnt_ff >= carrier_len_ff |=> carrier_start) // RULE2
      else $error("carrier counter did not wrap at its period");
   thermal_set_a: assert property ( // RULE7
      overtemp_set_level_i |=> thermal_cutoff_ff && !gates_any)
      else $error("thermal cutoff not set above the set level");
   stall_off_a: assert property (stall_h.active |=> !gates_any && fault_out_o) // RULE10
      else $error("gates on or fault low during stall hold");
   stall_restart_a: assert property (sense_moved |=> stall_cnt_ff == 32'd0) // RULE9 RULE20
      else $error("stall count not restarted by a sensor change");
   trap_rev_a: assert property ( // RULE17
      drive_ff == DRV_TRAP |-> $past(sense) == 3'b010 && !$past(direction_select_i)
      |-> gate_hi_o == 3'b010 && gate_lo_o == 3'b100)
      else $error("reverse table wrong for sensor state 010");
   // sine requests are registered once, so compare with last cycle's inputs
   sine_pass_a: assert property ( // RULE13 RULE15
      drive_ff == DRV_SINE |-> gate_hi_o == $past(sine_hi_i) && gate_lo_o == $past(sine_lo_i))
      else $error("sine requests not passed to the gates");
endmodule

// *** logic/motor_guard_map.svh ***
// constants for the motor protection sequencer: offsets, fields, resets, timings
// assumes a 100 MHz system clock; included by bare name
`ifndef MOTOR_GUARD_MAP_SVH
`define MOTOR_GUARD_MAP_SVH

`define CLK_PERIOD_NS 10
`define CLK_HZ 100000000
// least times in ns, round up to cycles
`define LIMIT_BLANK_NS 1900
`define TRIP_BLANK_NS 1300
`define LIMIT_BLANK_CYC ((`LIMIT_BLANK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TRIP_BLANK_CYC ((`TRIP_BLANK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// hold and stall times
`define TRIP_HOLD_MS 15
`define STALL_DETECT_S 6
`define STALL_HOLD_S 35
`define TRIP_HOLD_CYC (64'(`TRIP_HOLD_MS) * 64'(`CLK_HZ) / 64'd1000)
`define STALL_DETECT_CYC (64'(`STALL_DETECT_S) * 64'(`CLK_HZ))
`define STALL_HOLD_CYC (64'(`STALL_HOLD_S) * 64'(`CLK_HZ))

// register byte offsets
`define REG_CTRL 8'h00
`define REG_CARRIER 8'h04
`define REG_STATUS 8'h08
`define REG_SENSE 8'h0c
// control fields
`define CTRL_ENABLE_BIT 0
`define CTRL_RESET 32'h0000_0000
`define CARRIER_W 16
`define CARRIER_RESET 16'h1388
// status fields
`define ST_LIMIT_BIT 0
`define ST_TRIP_BIT 1
`define ST_THERMAL_BIT 2
`define ST_STALL_BIT 3
`define ST_REVERSE_BIT 4
`define ST_SENSOR_BIT 5
`define ST_TRAP_BIT 6
`define ST_FAULT_BIT 7
`define ST_ROT_FWD_BIT 8
`define ST_ROT_SEEN_BIT 9

`endif

// *** logic/motor_guard_pkg.sv ***
// types shared by the motor protection sequencer modules
// assumes nothing beyond the map header for numbers
package motor_guard_pkg;
   typedef logic [2:0] phase_t;
   typedef logic [2:0] sector_t;
   typedef enum logic [2:0] {
      DRV_OFF = 3'b001,
      DRV_SINE = 3'b010,
      DRV_TRAP = 3'b100
   } drive_state_t;
endpackage

// *** tb/mcu_model.sv ***
// external controller model: sine gate requests toward the guard, withdrawn on fault
// assumes clk_sys_i is shared with the guard; the bench picks the request pattern
`timescale 1ns/1ps
module mcu_model #(
   parameter int unsigned RESTART_GAP = 4
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic fault_out_i,
   input wire logic [5:0] pattern_i,
   output logic [2:0] sine_hi_o,
   output logic [2:0] sine_lo_o
);
   logic [7:0] gap_ff;
   logic quiet;

   // a real controller stops at once and waits before driving again
   assign quiet = rst_i || fault_out_i || (gap_ff != 8'h00);

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         gap_ff <= 8'h00;
      end else if (fault_out_i) begin
         gap_ff <= 8'(RESTART_GAP);
      end else if (gap_ff != 8'h00) begin
         gap_ff <= gap_ff - 8'h01;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      sine_hi_o <= quiet ? 3'h0 : pattern_i[5:3];
      sine_lo_o <= quiet ? 3'h0 : pattern_i[2:0];
   end
endmodule

// *** tb/motor_guard_tb_top.sv ***
// self-checking bench for the motor protection sequencer
// assumes the design files and the controller model are compiled before it
`timescale 1ns/1ps
`include "motor_guard_map.svh"
module motor_guard_tb_top;
   import motor_guard_pkg::*;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic limit_threshold_i = 1'b0;
   logic trip_threshold_i = 1'b0;
   logic overtemp_set_level_i = 1'b0;
   logic overtemp_clear_level_i = 1'b1;
   logic [2:0] sense = 3'h5;
   logic direction_select_i = 1'b1;
   logic [2:0] sine_hi, sine_lo;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [31:0] rdata_o;
   logic [2:0] gate_hi_o, gate_lo_o;
   logic fault_out_o, trap_mode_o;
   logic [5:0] pattern = 6'h00;
   logic [2:0] h, l;
   logic [2:0] fs [6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
   int err_total = 0;
   int samples_checked = 0;
   int n, k, st;

   motor_guard #(.TRIP_HOLD_CYC(32'd50), .STALL_DETECT_CYC(32'd600),
      .STALL_HOLD_CYC(32'd60)) motor_guard_inst (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .limit_threshold_i(limit_threshold_i),
      .trip_threshold_i(trip_threshold_i), .overtemp_set_level_i(overtemp_set_level_i),
      .overtemp_clear_level_i(overtemp_clear_level_i), .rotor_sense_u_i(sense[2]),
      .rotor_sense_v_i(sense[1]), .rotor_sense_w_i(sense[0]),
      .direction_select_i(direction_select_i), .sine_hi_i(sine_hi), .sine_lo_i(sine_lo),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .gate_hi_o(gate_hi_o), .gate_lo_o(gate_lo_o), .fault_out_o(fault_out_o),
      .trap_mode_o(trap_mode_o));

   mcu_model mcu_model_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .fault_out_i(fault_out_o),
      .pattern_i(pattern), .sine_hi_o(sine_hi), .sine_lo_o(sine_lo));

   always #5 clk_sys_i = ~clk_sys_i;

   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // {hi, lo} per table row; the reverse table is the forward list turned by three rows
   function automatic logic [5:0] trap_gates(input int idx, input logic d);
      int i;
      i = d ? idx : (idx + 3) % 6;
      case (i)
         0: return 6'h14;
         1: return 6'h0c;
         2: return 6'h0a;
         3: return 6'h22;
         4: return 6'h21;
         default: return 6'h11;
      endcase
   endfunction

   function automatic logic probe(input int w);
      case (w)
         0: return fault_out_o;
         1: return trap_mode_o;
         default: return |{gate_hi_o, gate_lo_o};
      endcase
   endfunction

   task automatic wait_until(input int w, input logic v, input int bound, output int cnt);
      for (cnt = 0; cnt < bound; cnt++) begin
         @(negedge clk_sys_i);
         if (probe(w) === v) return;
      end
      err_total++;
      $display("unexpected timeout probe %0d expected %b seen %b", w, v, probe(w));
      final_report();
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp, input string name);
      @(posedge clk_sys_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      @(negedge clk_sys_i);
      check(name, rdata_o, exp);
   endtask

   // sensors are set during reset so no rotation step is seen afterwards
   task automatic start(input logic [2:0] s, input logic d);
      @(posedge clk_sys_i);
      rst_i <= 1'b1;
      sense <= s;
      direction_select_i <= d;
      limit_threshold_i <= 1'b0;
      trip_threshold_i <= 1'b0;
      overtemp_set_level_i <= 1'b0;
      overtemp_clear_level_i <= 1'b1;
      repeat (6) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      @(negedge clk_sys_i);
      check("reset_state", {26'h0, gate_hi_o, gate_lo_o, fault_out_o, trap_mode_o}, 32'h1);
      reg_wr(`REG_CTRL, 32'h1);
      repeat (3) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
   endtask

   task automatic gates_ok(input int idx);
      check("gates", 32'({gate_hi_o, gate_lo_o}), 32'(trap_gates(idx, direction_select_i)));
   endtask

   initial begin
      void'($urandom(24516));
      start(fs[0], 1'b1);
      reg_rd(`REG_CARRIER, 32'(`CARRIER_RESET), "carrier");
      reg_rd(`REG_CTRL, 32'h1, "ctrl");
      reg_rd(`REG_STATUS, 32'h40, "status");
      reg_rd(`REG_SENSE, 32'h05, "sense");
      reg_rd(8'h10, 32'h0, "unmapped");
      for (int d = 0; d < 2; d++) begin
         for (int i = 0; i < 6; i++) begin
            start(fs[i], d[0]);
            gates_ok(i);
         end
      end
      // all-equal sensor states
      for (int v = 0; v < 2; v++) begin
         @(posedge clk_sys_i);
         sense <= v ? 3'h7 : 3'h0;
         wait_until(0, 1'b1, 4, n);
         check("sensor_gates", 32'({gate_hi_o, gate_lo_o}), 32'h0);
         @(posedge clk_sys_i);
         sense <= fs[0];
         wait_until(0, 1'b0, 4, n);
         gates_ok(0);
      end
      // thermal cutoff with hysteresis
      @(posedge clk_sys_i);
      overtemp_set_level_i <= 1'b1;
      overtemp_clear_level_i <= 1'b0;
      wait_until(2, 1'b0, 4, n);
      check("thermal_fault", 32'(fault_out_o), 32'h1);
      @(posedge clk_sys_i);
      overtemp_set_level_i <= 1'b0;
      repeat (6) @(negedge clk_sys_i);
      check("thermal_hyst", 32'({fault_out_o, gate_hi_o, gate_lo_o}), 32'h40);
      @(posedge clk_sys_i);
      overtemp_clear_level_i <= 1'b1;
      wait_until(0, 1'b0, 4, n);
      gates_ok(0);
      // trip: a short pulse is ignored, a long one holds the gates off
      start(fs[0], 1'b1);
      @(posedge clk_sys_i);
      trip_threshold_i <= 1'b1;
      repeat (100 + $urandom % 25) @(posedge clk_sys_i);
      trip_threshold_i <= 1'b0;
      repeat (40) @(negedge clk_sys_i);
      check("trip_glitch", 32'(fault_out_o), 32'h0);
      @(posedge clk_sys_i);
      trip_threshold_i <= 1'b1;
      wait_until(0, 1'b1, 200, n);
      check("trip_delay", 32'(n >= 128 && n <= 134), 32'h1);
      check("trip_gates", 32'({gate_hi_o, gate_lo_o}), 32'h0);
      @(posedge clk_sys_i);
      trip_threshold_i <= 1'b0;
      wait_until(0, 1'b0, 80, n);
      check("trip_hold", 32'(n >= 47 && n <= 52), 32'h1);
      repeat (2) @(negedge clk_sys_i);
      gates_ok(0);
      // limit cut, released at a carrier start
      start(fs[0], 1'b1);
      reg_wr(`REG_CARRIER, 32'd99);
      @(posedge clk_sys_i);
      limit_threshold_i <= 1'b1;
      repeat (1 + $urandom % 150) @(posedge clk_sys_i);
      limit_threshold_i <= 1'b0;
      repeat (5) @(negedge clk_sys_i);
      gates_ok(0);
      @(posedge clk_sys_i);
      limit_threshold_i <= 1'b1;
      wait_until(2, 1'b0, 200, n);
      check("limit_delay", 32'(n >= 188 && n <= 194), 32'h1);
      check("limit_fault", 32'(fault_out_o), 32'h0);
      @(posedge clk_sys_i);
      limit_threshold_i <= 1'b0;
      wait_until(2, 1'b1, 110, n);
      gates_ok(0);
      // stall on static sensors
      start(fs[0], 1'b1);
      wait_until(0, 1'b1, 700, n);
      check("stall_delay", 32'(n >= 585 && n <= 605), 32'h1);
      check("stall_gates", 32'({gate_hi_o, gate_lo_o}), 32'h0);
      wait_until(0, 1'b0, 100, n);
      check("stall_hold", 32'(n >= 58 && n <= 62), 32'h1);
      // rotation with and against each selected direction
      for (int d = 0; d < 2; d++) begin
         st = d ? 1 : 5;
         k = 0;
         start(fs[0], d[0]);
         for (int j = 0; j < 5; j++) begin
            k = (j == 2) ? (k + 6 - st) % 6 : (k + st) % 6;
            @(posedge clk_sys_i);
            sense <= fs[k];
            if (j == 2) begin
               wait_until(1, 1'b1, 3, n);
               wait_until(0, 1'b1, 3, n);
            end else begin
               h = 3'($urandom);
               l = ~h & 3'($urandom);
               pattern <= {h, l};
               repeat (14) @(negedge clk_sys_i);
               if (j != 0) begin
                  check("fault_match", 32'(fault_out_o), 32'h0);
                  check("sine_mode", 32'(trap_mode_o), 32'h0);
                  check("sine_gates", 32'({gate_hi_o, gate_lo_o}), 32'({h, l}));
               end
            end
         end
      end
      final_report();
   end
endmodule
